/* hdl/mqpc_defines.svh */
`ifndef MQPC_DEFINES_SVH
`define MQPC_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define MQPC_OFS_CTRL 12'h200
`define MQPC_OFS_IF_TOP 12'h204
`define MQPC_OFS_IF_BOT 12'h208
`define MQPC_OFS_IRQ_STS 12'h220
`define MQPC_OFS_IRQ_MSK 12'h224

// ****************************************
// control and pointer register field positions
// ****************************************
`define MQPC_BASE_LSB 20
`define MQPC_EMPTY_LSB 12
`define MQPC_FULL_LSB 8
`define MQPC_SIZE_LSB 4
`define MQPC_RBO_BIT 1
`define MQPC_DIS_BIT 0
`define MQPC_PTR_LSB 2

// ****************************************
// reset values and markers
// ****************************************
`define MQPC_RST_BASE 12'h000
`define MQPC_RST_SIZE 3'h0
`define MQPC_RST_PTR 18'h00000
`define MQPC_RST_EMPTY 4'hF
`define MQPC_RST_FULL 4'h0
`define MQPC_EQ_MARK 32'h0FFFFFFF
`define MQPC_ALL_ONES 32'hFFFFFFFF

// ****************************************
// entry index masks per depth select
// ****************************************
`define MQPC_MASK_256 18'h000FF
`define MQPC_MASK_1K 18'h003FF
`define MQPC_MASK_4K 18'h00FFF
`define MQPC_MASK_16K 18'h03FFF
`define MQPC_MASK_64K 18'h0FFFF

`endif

/* hdl/mqpc_pkg.sv */
package mqpc_pkg;

  // depth select codes
  typedef enum logic [2:0] {
    MQPC_D256 = 3'h0,
    MQPC_D1K = 3'h1,
    MQPC_D4K = 3'h2,
    MQPC_D16K = 3'h3,
    MQPC_D64K = 3'h4
  } mqpc_depth_e;

  typedef logic [17:0] mqpc_ptr_t;

  typedef struct packed {
    logic [11:0] base;
    logic [2:0] size;
    logic rbo;
    logic qdis;
    logic [3:0][17:0] top;
    logic [3:0][17:0] bot;
    logic [3:0] empty;
    logic [3:0] full;
    logic [7:0] sts;
    logic [7:0] msk;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] q_rdata;
    logic q_rvalid;
  } mqpc_state_s;

endpackage

/* hdl/mqpc_top.sv */
// Functional notes
// - writable queue region base in bits 31:20, one-megabyte aligned
// - four equal-size queues; only queue 0 can be placed anywhere inside the base region, queues 1..3 stay at its start
// - read-only empty flag per queue, one when empty, set by reset
// - read-only full flag per queue, one when full, cleared by reset
// - depth select 0..4 gives 256, 1K, 4K, 16K, 64K entries
// - entries are 32-bit words; total memory is four single queues
// - bottom-read option zero returns the real bottom pointer
// - option one with equal pointers returns the marker value instead
// - access-disable bit set: queue writes dropped, queue reads return all ones
// - pointer registers show the region base read-only in bits 31:20
// - device advances inbound free bottom by four, wrapping at depth
//
// The implementer's own choice: register access over APB.
`include "mqpc_defines.svh"

module mqpc_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // queue side accesses, push and pop one bit per queue, one shared read return
  input wire logic [3:0] q_push,
  input wire logic [3:0] q_pop,
  output logic [31:0] q_rdata,
  output logic q_rvalid,
  // flags and interrupt
  output logic [3:0] q_empty,
  output logic [3:0] q_full,
  output logic irq
);

  mqpc_pkg::mqpc_state_s s_q;
  mqpc_pkg::mqpc_state_s s_d;

  logic [17:0] idx_mask;
  logic [3:0][17:0] top_inc;
  logic [3:0][17:0] bot_inc;
  logic [3:0] nx_empty;
  logic [3:0] nx_full;
  logic acc;
  logic wr_acc;
  logic [31:0] ctrl_rd;
  logic [31:0] bot_rd;

  // ****************************************
  // depth decode
  // ****************************************
  always_comb begin
    unique case (mqpc_pkg::mqpc_depth_e'(s_q.size))
      mqpc_pkg::MQPC_D256: idx_mask = `MQPC_MASK_256;
      mqpc_pkg::MQPC_D1K: idx_mask = `MQPC_MASK_1K;
      mqpc_pkg::MQPC_D4K: idx_mask = `MQPC_MASK_4K;
      mqpc_pkg::MQPC_D16K: idx_mask = `MQPC_MASK_16K;
      mqpc_pkg::MQPC_D64K: idx_mask = `MQPC_MASK_64K;
      default: idx_mask = `MQPC_MASK_256;
    endcase
  end

  // ****************************************
  // per-queue pointer arithmetic
  // ****************************************
  for (genvar g = 0; g < 4; g++) begin : g_q
    // one entry is one word, so four bytes per step, wrapped at depth
    assign top_inc[g] = (s_q.top[g] & ~idx_mask) | ((s_q.top[g] + 18'h00001) & idx_mask);
    assign bot_inc[g] = (s_q.bot[g] & ~idx_mask) | ((s_q.bot[g] + 18'h00001) & idx_mask);
  end

  // ****************************************
  // register read views
  // ****************************************
  assign acc = psel && penable && s_q.pready;
  assign wr_acc = acc && pwrite && !s_q.pslverr;

  always_comb begin
    ctrl_rd = 32'h00000000;
    ctrl_rd[31:`MQPC_BASE_LSB] = s_q.base;
    ctrl_rd[`MQPC_EMPTY_LSB +: 4] = {s_q.empty[0], s_q.empty[1], s_q.empty[2], s_q.empty[3]};
    ctrl_rd[`MQPC_FULL_LSB +: 4] = {s_q.full[0], s_q.full[1], s_q.full[2], s_q.full[3]};
    ctrl_rd[`MQPC_SIZE_LSB +: 3] = s_q.size;
    ctrl_rd[`MQPC_RBO_BIT] = s_q.rbo;
    ctrl_rd[`MQPC_DIS_BIT] = s_q.qdis;
    if (s_q.rbo && ((s_q.top[0] ^ s_q.bot[0]) & idx_mask) == 18'h00000) begin
      bot_rd = `MQPC_EQ_MARK;
    end else begin
      bot_rd = {s_q.base, s_q.bot[0], 2'h0};
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.q_rvalid = 1'b0;
    // apb: one wait state, answer in second access cycle
    s_d.pready = psel && penable && !s_q.pready;
    // error stands only with pready
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      unique case (paddr)
        `MQPC_OFS_CTRL: s_d.prdata = ctrl_rd;
        `MQPC_OFS_IF_TOP: s_d.prdata = {s_q.base, s_q.top[0], 2'h0};
        `MQPC_OFS_IF_BOT: s_d.prdata = bot_rd;
        `MQPC_OFS_IRQ_STS: s_d.prdata = {24'h000000, s_q.sts};
        `MQPC_OFS_IRQ_MSK: s_d.prdata = {24'h000000, s_q.msk};
        default: begin
          s_d.prdata = 32'h00000000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        `MQPC_OFS_CTRL: begin
          s_d.base = pwdata[31:`MQPC_BASE_LSB];
          s_d.size = pwdata[`MQPC_SIZE_LSB +: 3];
          s_d.rbo = pwdata[`MQPC_RBO_BIT];
          s_d.qdis = pwdata[`MQPC_DIS_BIT];
        end
        `MQPC_OFS_IF_TOP: s_d.top[0] = pwdata[19:`MQPC_PTR_LSB];
        `MQPC_OFS_IF_BOT: s_d.bot[0] = pwdata[19:`MQPC_PTR_LSB];
        `MQPC_OFS_IRQ_STS: s_d.sts = s_q.sts & ~pwdata[7:0];
        `MQPC_OFS_IRQ_MSK: s_d.msk = pwdata[7:0];
        default: s_d.msk = s_q.msk;
      endcase
    end
    // queue-side accesses, dropped while disabled
    for (int i = 0; i < 4; i++) begin
      if (q_push[i] && !s_q.qdis && i != 0) begin
        s_d.top[i] = top_inc[i];
      end
      if (q_pop[i] && !s_q.qdis) begin
        s_d.bot[i] = bot_inc[i];
      end
    end
    if (|q_pop) begin
      s_d.q_rvalid = 1'b1;
      s_d.q_rdata = `MQPC_ALL_ONES;
      for (int i = 3; i >= 0; i--) begin
        if (q_pop[i] && !s_q.qdis) begin
          s_d.q_rdata = {s_q.base, s_q.bot[i], 2'h0};
        end
      end
    end
    // flags follow every pointer change, compared modulo depth
    for (int i = 0; i < 4; i++) begin
      nx_empty[i] = ((s_d.top[i] ^ s_d.bot[i]) & idx_mask) == 18'h00000;
      nx_full[i] = (((s_d.top[i] + 18'h00001) ^ s_d.bot[i]) & idx_mask) == 18'h00000;
    end
    s_d.empty = nx_empty;
    s_d.full = nx_full;
    // sticky events: became non-empty, became full; set wins over clear
    for (int i = 0; i < 4; i++) begin
      if (s_q.empty[i] && !nx_empty[i]) begin
        s_d.sts[i] = 1'b1;
      end
      if (!s_q.full[i] && nx_full[i]) begin
        s_d.sts[4 + i] = 1'b1;
      end
    end
    s_d.irq = |(s_d.sts & s_d.msk);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.base <= `MQPC_RST_BASE;
      s_q.size <= `MQPC_RST_SIZE;
      s_q.empty <= `MQPC_RST_EMPTY;
      s_q.full <= `MQPC_RST_FULL;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign q_rdata = s_q.q_rdata;
  assign q_rvalid = s_q.q_rvalid;
  assign q_empty = s_q.empty;
  assign q_full = s_q.full;
  assign irq = s_q.irq;

endmodule

/* sim/mqpc_qside.sv */
// ********
// queue side accesses
// ********
module mqpc_qside (
  input wire logic ref_clk,
  output logic [3:0] q_push,
  output logic [3:0] q_pop
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    q_push = 4'h0;
    q_pop = 4'h0;
  end
  // one-cycle pop pulse, released on the next edge
  task automatic pop(input logic [3:0] m);
    @(posedge ref_clk) q_pop <= m;
    @(posedge ref_clk) q_pop <= 4'h0;
  endtask
  // one-cycle push pulse, released on the next edge
  task automatic push(input logic [3:0] m);
    @(posedge ref_clk) q_push <= m;
    @(posedge ref_clk) q_push <= 4'h0;
  endtask
endmodule

/* sim/mqpc_sva.sv */
// ********
// checker
// ********
module mqpc_sva (
  input wire logic ref_clk, sys_rst, psel, penable, pready, pslverr, q_rvalid, irq,
  input wire logic [31:0] q_rdata,
  input wire logic [3:0] q_pop, q_empty, q_full
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdy_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  rdy_setup_a: assert property (psel && !penable |-> !pready)
    else $error("pready in setup cycle");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  pop_valid_a: assert property (|q_pop |=> q_rvalid)
    else $error("no q_rvalid after pop");
  valid_only_a: assert property (q_pop == 4'h0 |=> !q_rvalid)
    else $error("q_rvalid without pop");
  rdata_hold_a: assert property (q_pop == 4'h0 |=> $stable(q_rdata))
    else $error("q_rdata changed without pop");
  flag_excl_a: assert property ((q_empty & q_full) == 4'h0)
    else $error("queue empty and full at once");
  rst_vals_a: assert property (disable iff (1'b0) sys_rst |=> q_empty == 4'hF && q_full == 4'h0 && !irq)
    else $error("wrong values in reset");
endmodule
bind mqpc_top mqpc_sva mqpc_sva_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .q_rvalid(q_rvalid), .irq(irq), .q_rdata(q_rdata), .q_pop(q_pop),
  .q_empty(q_empty), .q_full(q_full));

/* sim/mqpc_top_tb_top.sv */
// ********
// bench
// ********
module mqpc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, q_rvalid, irq, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q_rdata, rd;
  logic [3:0] q_push, q_pop, q_empty, q_full;
  int errors = 0, compares = 0;
  always #5 ref_clk = ~ref_clk;
  mqpc_top mqpc_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .q_push(q_push), .q_pop(q_pop), .q_rdata(q_rdata), .q_rvalid(q_rvalid), .q_empty(q_empty),
    .q_full(q_full), .irq(irq));
  mqpc_qside mqpc_qside_inst (.ref_clk(ref_clk), .q_push(q_push), .q_pop(q_pop));
  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk) penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin
      errors++;
      test_done();
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(0, 12'h200, 0); chk(rd, 32'h0000F000);
    apb(0, 12'h204, 0); chk(rd, 32'h00000000);
    apb(0, 12'h208, 0); chk(rd, 32'h00000000);
    $display("reset test done");
    apb(1, 12'h200, 32'hABC00000); apb(0, 12'h200, 0); chk(rd, 32'hABC0F000);
    apb(1, 12'h204, 32'hFFF00010); apb(0, 12'h204, 0); chk(rd, 32'hABC00010);
    apb(0, 12'h200, 0); chk(rd, 32'hABC07000);
    chk({28'h0, q_empty}, 32'h0000000E);
    chk({31'h0, irq}, 32'h0);
    apb(1, 12'h224, 32'h00000001); repeat (2) @(posedge ref_clk); chk({31'h0, irq}, 32'h1);
    apb(1, 12'h220, 32'h000000FF); repeat (2) @(posedge ref_clk); chk({31'h0, irq}, 32'h0);
    $display("pointer test done");
    for (int i = 0; i < 4; i++) begin
      mqpc_qside_inst.pop(4'h1);
      #1 chk(q_rdata, 32'hABC00000 | (32'(i) << 2));
    end
    apb(0, 12'h208, 0); chk(rd, 32'hABC00010);
    apb(0, 12'h200, 0); chk(rd, 32'hABC0F000);
    apb(1, 12'h200, 32'hABC00002); apb(0, 12'h208, 0); chk(rd, 32'h0FFFFFFF);
    apb(1, 12'h204, 32'h0000000C); apb(0, 12'h200, 0); chk(rd, 32'hABC07802);
    chk({28'h0, q_full}, 32'h00000001);
    repeat (255) mqpc_qside_inst.pop(4'h1);
    apb(0, 12'h200, 0); chk(rd, 32'hABC0F002);
    apb(1, 12'h200, 32'hABC00000); apb(0, 12'h208, 0); chk(rd, 32'hABC0000C);
    $display("wrap test done");
    apb(1, 12'h200, 32'hABC00001); mqpc_qside_inst.pop(4'h1);
    #1 chk(q_rdata, 32'hFFFFFFFF);
    apb(0, 12'h208, 0); chk(rd, 32'hABC0000C);
    apb(1, 12'h200, 32'hABC00041); apb(0, 12'h200, 0); chk(rd, 32'hABC0F041);
    apb(0, 12'h100, 0); chk({er, rd[30:0]}, 32'h80000000);
    $display("disable test done");
    for (int c = 0; c < 5; c++) begin
      apb(1, 12'h200, 32'hABC00000 | (32'(c) << 4));
      apb(1, 12'h204, (32'h00000100 << (2 * c)) + 32'h00000008);
      apb(0, 12'h200, 0); chk(rd, 32'hABC07000 | (32'(c) << 4));
      apb(1, 12'h204, (32'h00000400 << (2 * c)) + 32'h00000008);
      apb(0, 12'h200, 0); chk(rd, 32'hABC07800 | (32'(c) << 4));
    end
    $display("depth test done");
    apb(1, 12'h200, 32'hABC00001); apb(1, 12'h204, 32'h0000000C);
    apb(1, 12'h200, 32'hABC00000);
    mqpc_qside_inst.push(4'hF);
    #1 chk({28'h0, q_empty}, 32'h00000001);
    mqpc_qside_inst.pop(4'hE);
    #1 chk(q_rdata, 32'hABC00000);
    chk({28'h0, q_empty}, 32'h0000000F);
    apb(1, 12'h200, 32'hABC00001); mqpc_qside_inst.push(4'hE);
    #1 chk({28'h0, q_empty}, 32'h0000000F);
    $display("queue side test done");
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(0, 12'h200, 0); chk(rd, 32'h0000F000);
    apb(0, 12'h204, 0); chk(rd, 32'h00000000);
    chk({28'h0, q_empty}, 32'h0000000F);
    $display("second reset test done");
    test_done();
  end
endmodule
